/* File: vlm_pkg.sv */
// Package for the output-voltage limit monitor: command codes, formats, steps, status layout.
// Assumes a PMBus command decoder upstream that delivers whole word reads and writes.
package vlm_pkg;

  // Command codes of the three limit words
  localparam logic [7:0] VLM_CMD_HIGH_WARN = 8'h42;
  localparam logic [7:0] VLM_CMD_LOW_WARN = 8'h43;
  localparam logic [7:0] VLM_CMD_LOW_FAULT = 8'h44;

  localparam int VLM_WORD_W = 16;
  localparam int VLM_PCT_W = 12;

  // Percentages are held in tenths of a percent
  localparam logic [11:0] VLM_PCT_SCALE = 12'h3E8;
  localparam logic [11:0] VLM_HW_MIN = 12'h406;
  localparam logic [11:0] VLM_HW_MAX = 12'h488;
  localparam logic [11:0] VLM_HW_STEP = 12'h00A;
  localparam logic [11:0] VLM_LW_MIN = 12'h348;
  localparam logic [11:0] VLM_LW_MAX = 12'h3CA;
  localparam logic [11:0] VLM_LW_STEP = 12'h00A;
  localparam logic [11:0] VLM_LF_MIN = 12'h258;
  localparam logic [11:0] VLM_LF_MAX = 12'h3B6;
  localparam logic [11:0] VLM_LF_STEP = 12'h019;

  // Relative format: value is a fraction of the target with this many fraction bits
  localparam int VLM_REL_FRAC = 12;

  // Status bit positions of the output-voltage status byte
  localparam int VLM_SV_HIGH_WARN = 6;
  localparam int VLM_SV_LOW_WARN = 5;
  localparam int VLM_SV_LOW_FAULT = 4;
  // Status word bit for the output-voltage summary
  localparam int VLM_SW_VOUT = 15;
  // Communication status: invalid data bit
  localparam int VLM_CML_BAD_DATA = 6;

  typedef enum logic [1:0] {
    VLM_FMT_ABS = 2'b00,
    VLM_FMT_REL = 2'b01
  } vlm_fmt_t;

  typedef enum logic [1:0] {
    VLM_ROUND_UP = 2'b00,
    VLM_ROUND_DOWN = 2'b01
  } vlm_round_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] cmd;
    logic [15:0] data;
  } vlm_req_t;

  typedef struct packed {
    logic clr_status;
    logic [7:0] fault_action;
  } vlm_ctrl_t;

endpackage : vlm_pkg

/* File: vlm_pct_map.sv */
// Maps a limit word into a supported hardware percentage and flags invalid values.
// Assumes a steady target voltage while a conversion is in use; purely combinational.
`timescale 1ns/10ps
module vlm_pct_map
  import vlm_pkg::*;
#(
  parameter logic [11:0] PCT_MIN = 12'h000,
  parameter logic [11:0] PCT_MAX = 12'h000,
  parameter logic [11:0] PCT_STEP = 12'h001,
  parameter vlm_round_t ROUND = VLM_ROUND_UP
) (
  input wire logic [15:0] limit_word,
  input wire logic [15:0] target_word,
  input wire vlm_fmt_t fmt,
  output logic [11:0] pct,
  output logic valid
);

  logic [31:0] raw_pct;
  logic [31:0] offs;
  logic [31:0] rem;
  logic [31:0] base;
  logic [31:0] rounded;

  // Word as tenths of a percent of the target
  always_comb begin
    raw_pct = 32'h0;
    if (fmt == VLM_FMT_REL) begin
      raw_pct = (32'(limit_word) * 32'(VLM_PCT_SCALE)) >> VLM_REL_FRAC;
    end else if (target_word != 16'h0) begin
      raw_pct = (32'(limit_word) * 32'(VLM_PCT_SCALE)) / 32'(target_word);
    end
  end

  assign offs = raw_pct - 32'(PCT_MIN);
  assign rem = offs % 32'(PCT_STEP);
  assign base = raw_pct - rem;
  assign rounded = (ROUND == VLM_ROUND_UP && rem != 32'h0) ? base + 32'(PCT_STEP) : base;
  assign valid = (raw_pct >= 32'(PCT_MIN)) && (raw_pct <= 32'(PCT_MAX)) &&
                 (rounded <= 32'(PCT_MAX));
  assign pct = valid ? rounded[11:0] : PCT_MIN;

endmodule : vlm_pct_map

/* File: vlm_cmp.sv */
// Compares sensed voltage with a percentage of the target; above or at-or-below.
// Assumes sensed and target words share one scale.
`timescale 1ns/10ps
module vlm_cmp
  import vlm_pkg::*;
#(
  parameter bit ABOVE = 1'b1
) (
  input wire logic [15:0] sensed,
  input wire logic [15:0] target,
  input wire logic [11:0] pct,
  output logic hit
);

  logic [31:0] lhs;
  logic [31:0] rhs;

  assign lhs = 32'(sensed) * 32'(VLM_PCT_SCALE);
  assign rhs = 32'(target) * 32'(pct);
  assign hit = ABOVE ? (lhs > rhs) : (lhs <= rhs);

endmodule : vlm_cmp

/* File: vlm_monitor.sv */
// Output-voltage limit supervision: three limit words, warning status, fault hand-off.
// Assumes a command decoder presenting one-cycle word requests and NVM reset values.
//
// Functional notes
// - Three 16-bit limit words, cleared to 0000 by reset and restored from NVM on nvm_load; the two warning words read by format setting.
// - Each limit becomes a fixed percentage of the present target.
// - Sensed voltage compared with the high warning threshold relative to target.
// - Target changes never rewrite stored limits in absolute format.
// - Above high warning sets summary and high warning flags, alerts host.
// - High warning rounds up; 103% to 116% in 1% steps.
// - Unsupported limit write is invalid data, sets communication flag, alerts.
// - Low warning sets summary and low warning flags, alerts host.
// - Low warning rounds down; 84% to 97% in 1% steps.
// - Reaching low fault threshold invokes selected undervoltage fault action.
// - Low fault rounds down; 60% to 95% in 2.5% steps.
// - Low fault limit always read in absolute unsigned linear format.
`timescale 1ns/10ps
module vlm_monitor
  import vlm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire vlm_req_t req,
  input wire vlm_ctrl_t ctrl,
  input wire vlm_fmt_t output_voltage_format,
  input wire logic [15:0] commanded_output_voltage,
  input wire logic [15:0] sensed_output_voltage,
  input wire logic nvm_load,
  input wire logic [15:0] nvm_high_warning_threshold,
  input wire logic [15:0] nvm_low_warning_threshold,
  input wire logic [15:0] nvm_low_fault_threshold,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic [7:0] output_voltage_status,
  output logic status_word_vout,
  output logic cml_invalid_data,
  output logic host_alert,
  output logic low_fault_trigger,
  output logic [7:0] low_fault_action,
  output logic [11:0] high_warning_pct,
  output logic [11:0] low_warning_pct,
  output logic [11:0] low_fault_pct
);

  ////////////////////////////////////////////////////////////////////////////////
  // Limit storage
  logic [15:0] hw_q;
  logic [15:0] hw_d;
  logic [15:0] lw_q;
  logic [15:0] lw_d;
  logic [15:0] lf_q;
  logic [15:0] lf_d;
  logic [11:0] hw_pct_q;
  logic [11:0] lw_pct_q;
  logic [11:0] lf_pct_q;

  logic sel_hw;
  logic sel_lw;
  logic sel_lf;
  logic wr_any;

  assign sel_hw = req.cmd == VLM_CMD_HIGH_WARN;
  assign sel_lw = req.cmd == VLM_CMD_LOW_WARN;
  assign sel_lf = req.cmd == VLM_CMD_LOW_FAULT;
  assign wr_any = req.wr && (sel_hw || sel_lw || sel_lf);

  // Candidate words checked before they are accepted
  logic [15:0] cand_hw;
  logic [15:0] cand_lw;
  logic [15:0] cand_lf;
  assign cand_hw = (req.wr && sel_hw) ? req.data : hw_q;
  assign cand_lw = (req.wr && sel_lw) ? req.data : lw_q;
  assign cand_lf = (req.wr && sel_lf) ? req.data : lf_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Percentage mapping
  logic [11:0] hw_pct;
  logic [11:0] lw_pct;
  logic [11:0] lf_pct;
  logic hw_ok;
  logic lw_ok;
  logic lf_ok;

  vlm_pct_map #(
    .PCT_MIN(VLM_HW_MIN),
    .PCT_MAX(VLM_HW_MAX),
    .PCT_STEP(VLM_HW_STEP),
    .ROUND(VLM_ROUND_UP)
  ) u_map_hw (
    .limit_word(cand_hw),
    .target_word(commanded_output_voltage),
    .fmt(output_voltage_format),
    .pct(hw_pct),
    .valid(hw_ok)
  );

  vlm_pct_map #(
    .PCT_MIN(VLM_LW_MIN),
    .PCT_MAX(VLM_LW_MAX),
    .PCT_STEP(VLM_LW_STEP),
    .ROUND(VLM_ROUND_DOWN)
  ) u_map_lw (
    .limit_word(cand_lw),
    .target_word(commanded_output_voltage),
    .fmt(output_voltage_format),
    .pct(lw_pct),
    .valid(lw_ok)
  );

  vlm_pct_map #(
    .PCT_MIN(VLM_LF_MIN),
    .PCT_MAX(VLM_LF_MAX),
    .PCT_STEP(VLM_LF_STEP),
    .ROUND(VLM_ROUND_DOWN)
  ) u_map_lf (
    .limit_word(cand_lf),
    .target_word(commanded_output_voltage),
    .fmt(VLM_FMT_ABS),
    .pct(lf_pct),
    .valid(lf_ok)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Write acceptance
  logic acc_hw;
  logic acc_lw;
  logic acc_lf;
  logic acc_any;
  logic bad_write;

  // Only a word that maps onto a supported step is stored
  assign acc_hw = req.wr && sel_hw && hw_ok;
  assign acc_lw = req.wr && sel_lw && lw_ok;
  assign acc_lf = req.wr && sel_lf && lf_ok;
  assign acc_any = acc_hw || acc_lw || acc_lf;
  assign bad_write = wr_any && !acc_any;

  // Stored words change only on accepted writes or NVM restore, never on target moves
  assign hw_d = nvm_load ? nvm_high_warning_threshold :
                acc_hw ? req.data : hw_q;
  assign lw_d = nvm_load ? nvm_low_warning_threshold :
                acc_lw ? req.data : lw_q;
  assign lf_d = nvm_load ? nvm_low_fault_threshold :
                acc_lf ? req.data : lf_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hw_q <= 16'h0000;
      lw_q <= 16'h0000;
      lf_q <= 16'h0000;
    end else begin
      hw_q <= hw_d;
      lw_q <= lw_d;
      lf_q <= lf_d;
    end
  end

  // Percentages follow the target; invalid candidates keep the last good step
  logic [11:0] hw_pct_d;
  logic [11:0] lw_pct_d;
  logic [11:0] lf_pct_d;
  assign hw_pct_d = hw_ok ? hw_pct : hw_pct_q;
  assign lw_pct_d = lw_ok ? lw_pct : lw_pct_q;
  assign lf_pct_d = lf_ok ? lf_pct : lf_pct_q;

  // Reset steps are the loosest supported ones until a valid word is restored or written
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hw_pct_q <= VLM_HW_MAX;
      lw_pct_q <= VLM_LW_MIN;
      lf_pct_q <= VLM_LF_MIN;
    end else begin
      hw_pct_q <= hw_pct_d;
      lw_pct_q <= lw_pct_d;
      lf_pct_q <= lf_pct_d;
    end
  end

  assign high_warning_pct = hw_pct_q;
  assign low_warning_pct = lw_pct_q;
  assign low_fault_pct = lf_pct_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Read path
  // Unmapped codes give no answer and leave rd_data as it was
  logic [15:0] rd_mux;
  logic rd_hit;
  assign rd_hit = req.rd && (sel_hw || sel_lw || sel_lf);
  assign rd_mux = sel_hw ? hw_q : sel_lw ? lw_q : sel_lf ? lf_q : 16'h0000;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rd_data <= 16'h0000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= rd_hit;
      if (rd_hit) rd_data <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Threshold comparison
  // Low comparisons include equality: reaching the threshold counts
  logic hw_hit;
  logic lw_hit;
  logic lf_hit;

  vlm_cmp #(.ABOVE(1'b1)) u_cmp_hw (
    .sensed(sensed_output_voltage),
    .target(commanded_output_voltage),
    .pct(hw_pct_q),
    .hit(hw_hit)
  );

  vlm_cmp #(.ABOVE(1'b0)) u_cmp_lw (
    .sensed(sensed_output_voltage),
    .target(commanded_output_voltage),
    .pct(lw_pct_q),
    .hit(lw_hit)
  );

  vlm_cmp #(.ABOVE(1'b0)) u_cmp_lf (
    .sensed(sensed_output_voltage),
    .target(commanded_output_voltage),
    .pct(lf_pct_q),
    .hit(lf_hit)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Sticky status; a new event wins over a clear in the same cycle
  logic hw_flag_q;
  logic lw_flag_q;
  logic lf_flag_q;
  logic cml_q;
  logic lf_prev_q;
  logic lf_rise;
  logic alert_q;
  logic [7:0] action_q;
  logic hw_flag_d;
  logic lw_flag_d;
  logic lf_flag_d;
  logic cml_d;
  logic alert_d;

  // Low fault pulses once per crossing; the response logic downstream acts on it
  assign lf_rise = lf_hit && !lf_prev_q;

  // Set terms come first so an event in the clearing cycle is not lost
  assign hw_flag_d = hw_hit || (hw_flag_q && !ctrl.clr_status);
  assign lw_flag_d = lw_hit || (lw_flag_q && !ctrl.clr_status);
  assign lf_flag_d = lf_rise || (lf_flag_q && !ctrl.clr_status);
  assign cml_d = bad_write || (cml_q && !ctrl.clr_status);
  assign alert_d = hw_flag_q || lw_flag_q || cml_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hw_flag_q <= 1'b0;
      lw_flag_q <= 1'b0;
      lf_flag_q <= 1'b0;
      cml_q <= 1'b0;
    end else begin
      hw_flag_q <= hw_flag_d;
      lw_flag_q <= lw_flag_d;
      lf_flag_q <= lf_flag_d;
      cml_q <= cml_d;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lf_prev_q <= 1'b0;
      low_fault_trigger <= 1'b0;
      action_q <= 8'h00;
    end else begin
      lf_prev_q <= lf_hit;
      low_fault_trigger <= lf_rise;
      action_q <= ctrl.fault_action;
    end
  end

  // Alert holds while a warning flag or the communication flag stands, not the low fault flag
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      alert_q <= 1'b0;
    end else begin
      alert_q <= alert_d;
    end
  end

  always_comb begin
    output_voltage_status = 8'h00;
    output_voltage_status[VLM_SV_HIGH_WARN] = hw_flag_q;
    output_voltage_status[VLM_SV_LOW_WARN] = lw_flag_q;
    output_voltage_status[VLM_SV_LOW_FAULT] = lf_flag_q;
  end

  assign status_word_vout = hw_flag_q || lw_flag_q || lf_flag_q;
  assign cml_invalid_data = cml_q;
  assign host_alert = alert_q;
  assign low_fault_action = action_q;

endmodule : vlm_monitor

/* File: vlm_monitor_assertions.sv */
// Checker for vlm_monitor: read answers, flag timing, step ranges, fault hand-off.
// Assumes it is bound to vlm_monitor and sees only its ports.
`timescale 1ns/10ps
module vlm_monitor_assertions
  import vlm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire vlm_req_t req,
  input wire vlm_ctrl_t ctrl,
  input wire logic [15:0] commanded_output_voltage,
  input wire logic [15:0] sensed_output_voltage,
  input wire logic rd_valid,
  input wire logic [7:0] output_voltage_status,
  input wire logic status_word_vout,
  input wire logic cml_invalid_data,
  input wire logic host_alert,
  input wire logic low_fault_trigger,
  input wire logic [7:0] low_fault_action,
  input wire logic [11:0] high_warning_pct,
  input wire logic [11:0] low_warning_pct,
  input wire logic [11:0] low_fault_pct
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  wire logic [31:0] sens_k = {16'h0000, sensed_output_voltage} * 32'h0000_03E8;
  wire logic [31:0] tgt = {16'h0000, commanded_output_voltage};
  wire logic over_hw = sens_k > tgt * {20'h00000, high_warning_pct};
  wire logic under_lw = sens_k <= tgt * {20'h00000, low_warning_pct};
  wire logic lf_hit = sens_k <= tgt * {20'h00000, low_fault_pct};
  wire logic rd_hit = req.rd & (req.cmd inside {8'h42, 8'h43, 8'h44});
  wire logic any_flag = output_voltage_status[6] | output_voltage_status[5] | cml_invalid_data;
  ////////////////////////////////////////////////////////////////////////////////
  AST_RD_VALID: assert property (rd_valid == $past(rd_hit))
    else $error("read answer timing wrong");
  AST_HW_SET: assert property (over_hw |=> output_voltage_status[6])
    else $error("high warning flag not set");
  AST_LW_SET: assert property (under_lw |=> output_voltage_status[5])
    else $error("low warning flag not set");
  AST_SUMMARY: assert property (status_word_vout == |output_voltage_status[6:4])
    else $error("summary bit disagrees with flags");
  AST_STICKY: assert property (!ctrl.clr_status |=>
    (output_voltage_status[6:5] & $past(output_voltage_status[6:5])) ==
    $past(output_voltage_status[6:5]))
    else $error("warning flag dropped without clear");
  AST_ALERT: assert property (host_alert == $past(any_flag))
    else $error("host alert does not follow flags");
  AST_HW_RANGE: assert property (high_warning_pct >= VLM_HW_MIN &&
    high_warning_pct <= VLM_HW_MAX && (high_warning_pct - VLM_HW_MIN) % VLM_HW_STEP == 12'h000)
    else $error("high warning step out of range");
  AST_LW_RANGE: assert property (low_warning_pct >= VLM_LW_MIN &&
    low_warning_pct <= VLM_LW_MAX && (low_warning_pct - VLM_LW_MIN) % VLM_LW_STEP == 12'h000)
    else $error("low warning step out of range");
  AST_LF_RANGE: assert property (low_fault_pct >= VLM_LF_MIN &&
    low_fault_pct <= VLM_LF_MAX && (low_fault_pct - VLM_LF_MIN) % VLM_LF_STEP == 12'h000)
    else $error("low fault step out of range");
  AST_LF_TRIG: assert property ($rose(lf_hit) |=> low_fault_trigger)
    else $error("low fault hand-off missing");
  AST_ACTION: assert property (low_fault_action == $past(ctrl.fault_action))
    else $error("fault action not passed on");
  COV_HW: cover property ($rose(output_voltage_status[6]));
  COV_LF: cover property (low_fault_trigger);
  COV_CML: cover property ($rose(cml_invalid_data));
endmodule : vlm_monitor_assertions

/* File: vlm_host.sv */
// Host model: single-cycle word reads and writes toward the limit monitor.
// Assumes the bench calls xfer; signals change on the falling clock edge.
`timescale 1ns/10ps
module vlm_host
  import vlm_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  output vlm_req_t req
);
  initial req = '0;
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [15:0] q, output logic v);
    @(negedge clk_sys);
    req = '{wr: w, rd: !w, cmd: c, data: d};
    @(negedge clk_sys);
    q = rd_data;
    v = rd_valid;
    // Released lines show the inverse, not a stale value
    req = '{wr: 1'b0, rd: 1'b0, cmd: ~c, data: ~d};
  endtask : xfer
endmodule : vlm_host

/* File: vlm_monitor_test.sv */
// Self-checking bench for vlm_monitor with a host model on the request port.
// Assumes target 1000 counts so absolute words equal tenths of a percent.
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin err_total++; \
  $display("unexpected at %0t: got %h want %h", $time, a, b); end end
module vlm_monitor_test;
  import vlm_pkg::*;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  vlm_req_t req;
  vlm_ctrl_t ctrl = '0;
  vlm_fmt_t output_voltage_format = VLM_FMT_ABS;
  logic [15:0] commanded_output_voltage = 16'h03E8;
  logic [15:0] sensed_output_voltage = 16'h03E8;
  logic nvm_load = 1'b0;
  logic [15:0] nvm_high_warning_threshold = 16'h041A;
  logic [15:0] nvm_low_warning_threshold = 16'h0384;
  logic [15:0] nvm_low_fault_threshold = 16'h02EE;
  logic [15:0] rd_data, rq;
  logic [7:0] output_voltage_status, low_fault_action;
  logic rd_valid, status_word_vout, cml_invalid_data, host_alert, low_fault_trigger, rv;
  logic [11:0] high_warning_pct, low_warning_pct, low_fault_pct;
  int err_total = 0;
  int n_checks = 0;
  always #5 clk_sys = ~clk_sys;
  vlm_host u_host (.clk_sys, .rd_data, .rd_valid, .req);
  vlm_monitor u_dut (.clk_sys, .rst, .req, .ctrl, .output_voltage_format,
    .commanded_output_voltage, .sensed_output_voltage, .nvm_load, .nvm_high_warning_threshold,
    .nvm_low_warning_threshold, .nvm_low_fault_threshold, .rd_data, .rd_valid,
    .output_voltage_status, .status_word_vout, .cml_invalid_data, .host_alert,
    .low_fault_trigger, .low_fault_action, .high_warning_pct, .low_warning_pct, .low_fault_pct);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys);
  endtask : cyc
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    u_host.xfer(1'b1, c, d, rq, rv);
  endtask : wr
  task automatic rd_chk(input logic [7:0] c, input logic [15:0] d);
    u_host.xfer(1'b0, c, 16'h0000, rq, rv);
    `CHK(rv, 1'b1)
    `CHK(rq, d)
  endtask : rd_chk
  task automatic clear();
    @(negedge clk_sys) ctrl.clr_status = 1'b1;
    @(negedge clk_sys) ctrl.clr_status = 1'b0;
    cyc(2);
  endtask : clear
  task automatic t_restore();
    @(negedge clk_sys) nvm_load = 1'b1;
    @(negedge clk_sys) nvm_load = 1'b0;
    rd_chk(8'h42, 16'h041A);
    rd_chk(8'h43, 16'h0384);
    rd_chk(8'h44, 16'h02EE);
    `CHK(high_warning_pct, 12'h41A)
  endtask : t_restore
  task automatic t_round();
    wr(8'h42, 16'h041F);
    wr(8'h43, 16'h0389);
    wr(8'h44, 16'h03B5);
    cyc(1);
    `CHK(high_warning_pct, 12'h424)
    `CHK(low_warning_pct, 12'h384)
    `CHK(low_fault_pct, 12'h39D)
    rd_chk(8'h42, 16'h041F);
  endtask : t_round
  task automatic t_refuse();
    wr(8'h42, 16'h0492);
    cyc(2);
    `CHK(cml_invalid_data, 1'b1)
    `CHK(host_alert, 1'b1)
    `CHK(high_warning_pct, 12'h424)
    rd_chk(8'h42, 16'h041F);
    u_host.xfer(1'b0, 8'h45, 16'h0000, rq, rv);
    `CHK(rv, 1'b0)
    clear();
    `CHK(cml_invalid_data, 1'b0)
  endtask : t_refuse
  task automatic t_warn();
    sensed_output_voltage = 16'h0424;
    cyc(3);
    `CHK(output_voltage_status[6], 1'b0)
    sensed_output_voltage = 16'h0425;
    cyc(3);
    `CHK(output_voltage_status[6], 1'b1)
    `CHK(status_word_vout, 1'b1)
    `CHK(host_alert, 1'b1)
    sensed_output_voltage = 16'h03E8;
    cyc(3);
    `CHK(output_voltage_status[6], 1'b1)
    clear();
    `CHK(output_voltage_status, 8'h00)
  endtask : t_warn
  task automatic t_low();
    int k;
    k = 0;
    ctrl.fault_action = 8'h81;
    sensed_output_voltage = 16'h039D;
    for (int i = 0; i < 6; i++) begin
      cyc(1);
      if (low_fault_trigger === 1'b1) k++;
    end
    `CHK(k, 1)
    `CHK(output_voltage_status[4], 1'b1)
    `CHK(output_voltage_status[5], 1'b0)
    `CHK(low_fault_action, 8'h81)
    sensed_output_voltage = 16'h0384;
    cyc(3);
    `CHK(output_voltage_status[5], 1'b1)
    `CHK(host_alert, 1'b1)
    sensed_output_voltage = 16'h03E8;
    clear();
  endtask : t_low
  task automatic t_target();
    commanded_output_voltage = 16'h07D0;
    sensed_output_voltage = 16'h07D0;
    cyc(2);
    rd_chk(8'h42, 16'h041F);
    rd_chk(8'h43, 16'h0389);
    commanded_output_voltage = 16'h03E8;
    sensed_output_voltage = 16'h03E8;
  endtask : t_target
  task automatic t_rel();
    output_voltage_format = VLM_FMT_REL;
    wr(8'h42, 16'h1100);
    wr(8'h44, 16'h02EE);
    cyc(1);
    `CHK(high_warning_pct, 12'h42E)
    `CHK(low_fault_pct, 12'h2EE)
  endtask : t_rel
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict
  initial begin
    cyc(20);
    rst = 1'b0;
    t_restore();
    t_round();
    t_refuse();
    t_warn();
    t_low();
    t_target();
    t_rel();
    print_verdict();
  end
  initial begin
    #20000;
    err_total++;
    print_verdict();
  end
endmodule : vlm_monitor_test
bind vlm_monitor vlm_monitor_assertions u_chk (.clk_sys, .rst, .req, .ctrl,
  .commanded_output_voltage, .sensed_output_voltage, .rd_valid, .output_voltage_status,
  .status_word_vout, .cml_invalid_data, .host_alert, .low_fault_trigger, .low_fault_action,
  .high_warning_pct, .low_warning_pct, .low_fault_pct);
